// ==== rtl/lbb_pkg.sv ====
// shared constants and types of the local bus bridge
package lbb_pkg;
  // window count, data width, burst length width and fifo depth
  localparam int LBB_WIN_NUM    = 6;
  localparam int LBB_DATA_W     = 64;
  localparam int LBB_BL_W       = 8;
  localparam int LBB_FIFO_DEPTH = 32;
  // window encodings
  localparam logic [31:0] LBB_WIN_NONE     = 32'h0000_0000; // parameter value meaning unused
  localparam logic [31:0] LBB_WIN_UNUSED   = 32'h0000_0002; // code handed to the core
  localparam logic [31:0] LBB_WIN_ALL_ONES = 32'hffff_ffff; // sizing write pattern
  localparam logic [31:0] LBB_WIN_RD_OFF   = 32'h0000_0000; // unused window read value
  localparam int          LBB_IO_BIT       = 0;             // space indicator bit
  localparam int          LBB_PF_BIT       = 3;             // prefetch flag bit
  localparam logic [1:0]  LBB_LOC_32       = 2'h0;          // locate in 32-bit space
  localparam logic [1:0]  LBB_LOC_64       = 2'h2;          // locate in 64-bit space
  localparam logic [31:0] LBB_IO_TYPE      = 32'h0000_0001; // io type bits
  localparam logic [31:0] LBB_LOW_WORD     = 32'hffff_ffff; // lower half data mask
  // pci command codes
  localparam logic [3:0]  LBB_CMD_SPECIAL  = 4'h1;
  localparam int          LBB_CMD_WR_BIT   = 0;             // odd commands are writes
  // byte enables of the unused upper half (active low, inactive)
  localparam logic [3:0]  LBB_BE_OFF       = 4'hf;
  // master phase, one-hot codes
  typedef enum logic [3:0] {
    LBB_M_TERM = 4'h1,
    LBB_M_ADDR = 4'h2,
    LBB_M_XACT = 4'h4
  } lbb_mphase_t;
endpackage

// ==== rtl/lbb_fifo.sv ====
// parameterised fifo with a registered read port
`timescale 1ns/1ps
module lbb_fifo #(
  parameter int WIDTH = lbb_pkg::LBB_DATA_W,
  parameter int DEPTH = lbb_pkg::LBB_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  import lbb_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0]  wptr;  // write pointer
    logic [AW-1:0]  rptr;  // read pointer
    logic [AW:0]    cnt;   // words held in the array
    logic           ovld;  // output register holds a word
    logic [WIDTH-1:0] odat; // output register
  } lbb_fifo_st_t;
  lbb_fifo_st_t s;
  lbb_fifo_st_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic             wr;           // word enters the array
  logic             rd;           // word moves to the output register
  // full is honest: ready drops once all entries hold data
  assign in_ready_o  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = s.ovld;
  assign out_data_o  = s.odat;
  // next state: pointers, count and the output register
  always_comb begin
    next_s = s;
    wr = in_valid_i && in_ready_o;
    rd = (s.cnt != '0) && (!s.ovld || out_ready_i);
    if (wr) begin
      next_s.wptr = (s.wptr == AW'(DEPTH-1)) ? '0 : s.wptr + 1'b1;
    end
    if (rd) begin
      next_s.rptr = (s.rptr == AW'(DEPTH-1)) ? '0 : s.rptr + 1'b1;
      next_s.odat = mem[s.rptr];
      next_s.ovld = 1'b1;
    end else if (out_ready_i) begin
      next_s.ovld = 1'b0;
    end
    next_s.cnt = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end
  // state register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // array writes carry no reset, it is plain storage
  always_ff @(posedge core_clk_i) begin
    if (wr) begin
      mem[s.wptr] <= in_data_i;
    end
  end
endmodule

// ==== rtl/lbb_core.sv ====
// local bus bridge: window setup, local target and local master control
`timescale 1ns/1ps
module lbb_core #(
  parameter int                     WIN_NUM  = lbb_pkg::LBB_WIN_NUM,
  parameter int                     DATA_W   = lbb_pkg::LBB_DATA_W,
  parameter int                     BL_W     = lbb_pkg::LBB_BL_W,
  parameter int                     FIFO_D   = lbb_pkg::LBB_FIFO_DEPTH,
  parameter logic [WIN_NUM*32-1:0]  WIN_PARAM = '0, // window_param_value per window
  parameter logic [WIN_NUM-1:0]     WIN_WIDE  = '0  // windows served over the wide bus
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  // configuration port of the windows
  input  wire logic                 cfg_wr_i,
  input  wire logic                 cfg_rd_i,
  input  wire logic [2:0]           cfg_idx_i,
  input  wire logic [31:0]          cfg_wdata_i,
  output logic [31:0]               cfg_rdata_o,
  // pci engine, target side
  input  wire logic                 pci_tgt_start_i,
  input  wire logic                 pci_tgt_end_i,
  input  wire logic [31:0]          pci_tgt_addr_i,
  input  wire logic [3:0]           pci_tgt_cmd_i,
  input  wire logic [7:0]           pci_tgt_be_i,
  input  wire logic                 pci_tgt_cap_hit_i,
  input  wire logic                 pci_tgt_rom_hit_i,
  input  wire logic                 pci_tgt_wvalid_i,
  input  wire logic [DATA_W-1:0]    pci_tgt_wdata_i,
  output logic                      pci_tgt_wready_o,
  output logic                      pci_tgt_rvalid_o,
  output logic [DATA_W-1:0]         pci_tgt_rdata_o,
  input  wire logic                 pci_tgt_rready_i,
  // local target
  output logic                      target_access_active_n_o,
  output logic [WIN_NUM-1:0]        window_hit_o,
  output logic                      cap_hit_o,
  output logic                      rom_hit_o,
  output logic [3:0]                target_command_code_o,
  output logic [7:0]                target_byte_enables_o,
  input  wire logic [DATA_W-1:0]    target_read_data_in_i,
  input  wire logic                 target_ready_n_i,
  output logic [DATA_W-1:0]         target_write_data_o,
  output logic                      target_low_transfer_n_o,
  output logic                      target_high_transfer_n_o,
  // local master
  input  wire logic                 master_narrow_request_n_i,
  input  wire logic                 master_wide_request_n_i,
  input  wire logic [31:0]          master_start_addr_i,
  input  wire logic [3:0]           master_command_in_i,
  input  wire logic [BL_W-1:0]      master_burst_len_i,
  output logic                      master_grant_n_o,
  output lbb_pkg::lbb_mphase_t      master_phase_state_o,
  output logic                      master_low_transfer_n_o,
  output logic                      master_high_transfer_n_o,
  // pci engine, master side
  input  wire logic                 pci_gnt_n_i,
  input  wire logic                 pci_mst_xfer_i,
  input  wire logic                 pci_mst_stop_i,
  output logic                      pci_req_n_o,
  output logic                      pci_mst_wide_o,
  output logic [31:0]               pci_mst_addr_o,
  output logic [3:0]                pci_mst_cmd_o,
  output logic [BL_W-1:0]           pci_mst_len_o
);
  import lbb_pkg::*;
  localparam logic [2:0]        IDX_LIM  = 3'(WIN_NUM);
  localparam logic [DATA_W-1:0] LOW_MASK = DATA_W'(LBB_LOW_WORD);
  localparam bit                BUS_WIDE = (DATA_W == 64);
  // whole state of the block
  typedef struct packed {
    logic [WIN_NUM-1:0][31:0] base;   // programmed window base
    logic [31:0]       cfg_rdata;     // configuration read data
    logic              acc_n;         // access active, low true
    logic [WIN_NUM-1:0] hit;          // window hits
    logic              cap;           // capability hit
    logic              rom;           // expansion rom hit
    logic [3:0]        cmd;           // current pci command
    logic [7:0]        be;            // byte enables to local target
    logic              rd;            // access is a read
    logic              wide;          // access uses both halves
    logic              lo_n;          // target low strobe
    logic              hi_n;          // target high strobe
    logic [DATA_W-1:0] wdata;         // write data to local target
    logic              wready;        // pci write data accepted
    lbb_mphase_t       phase;         // master phase
    logic              req_seen;      // request seen last cycle
    logic              gnt_seen;      // grant seen last cycle
    logic              preq_n;        // pci request
    logic              mgnt_n;        // local master grant
    logic [31:0]       maddr;         // latched start address
    logic [3:0]        mcmd;          // latched command
    logic [BL_W-1:0]   mlen;          // latched burst length
    logic [BL_W-1:0]   mcnt;          // data phases left
    logic              mwide;         // wide master transfer
    logic              mlo_n;         // master low strobe
    logic              mhi_n;         // master high strobe
  } lbb_state_t;
  lbb_state_t s;
  lbb_state_t next_s;
  // a zero parameter stands for an unused window
  function automatic logic [31:0] win_code(input logic [31:0] p);
    return (p == LBB_WIN_NONE) ? LBB_WIN_UNUSED : p;
  endfunction
  // size mask: io windows size from bit 2, memory windows from bit 4
  function automatic logic [31:0] win_mask(input logic [31:0] c);
    if (c[LBB_IO_BIT]) begin
      return {c[31:2], 2'b00};
    end
    return {c[31:4], 4'h0};
  endfunction
  // type bits; reserved locate codes fall back to 32-bit placement
  function automatic logic [31:0] win_type(input logic [31:0] c);
    if (c[LBB_IO_BIT]) begin
      return LBB_IO_TYPE;
    end
    return {28'h0, c[LBB_PF_BIT],
            (c[2:1] == LBB_LOC_64) ? LBB_LOC_64 : LBB_LOC_32, 1'b0};
  endfunction
  logic [WIN_NUM-1:0][31:0] wmask;    // size masks
  logic [WIN_NUM-1:0][31:0] wtype;    // type bits
  logic [WIN_NUM-1:0]       wen;      // window enabled
  logic [WIN_NUM-1:0]       whit;     // address falls in window
  logic                     fifo_rdy; // read fifo has room
  logic                     push;     // read word captured
  logic                     wtake;    // write word taken
  logic                     special;  // incoming special cycle
  logic                     idx_ok;   // configuration index in range
  logic                     req_any;  // either request asserted
  // per-window decode, computed once from the parameters and the bases
  for (genvar i = 0; i < WIN_NUM; i++) begin : g_win
    localparam logic [31:0] CODE = win_code(WIN_PARAM[i*32 +: 32]);
    assign wen[i]   = (CODE != LBB_WIN_UNUSED);
    assign wmask[i] = win_mask(CODE);
    assign wtype[i] = win_type(CODE);
    assign whit[i]  = wen[i] && ((pci_tgt_addr_i & wmask[i]) == s.base[i]);
  end
  // read path buffer; its ready holds off target strobes when full
  lbb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_rd_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push),
    .in_data_i   (target_read_data_in_i & (s.wide ? '1 : LOW_MASK)),
    .in_ready_o  (fifo_rdy),
    .out_valid_o (pci_tgt_rvalid_o),
    .out_data_o  (pci_tgt_rdata_o),
    .out_ready_i (pci_tgt_rready_i)
  );
  // next state of configuration, target and master sides
  always_comb begin
    next_s  = s;
    push    = 1'b0;
    wtake   = 1'b0;
    special = (pci_tgt_cmd_i == LBB_CMD_SPECIAL);
    idx_ok  = (cfg_idx_i < IDX_LIM);
    req_any = !master_narrow_request_n_i || !master_wide_request_n_i;
    // configuration: writes keep only size-field bits
    if (cfg_wr_i && idx_ok) begin
      next_s.base[cfg_idx_i] = cfg_wdata_i & wmask[cfg_idx_i];
    end
    if (cfg_rd_i) begin
      if (idx_ok && wen[cfg_idx_i]) begin
        next_s.cfg_rdata = s.base[cfg_idx_i] | wtype[cfg_idx_i];
      end else begin
        next_s.cfg_rdata = LBB_WIN_RD_OFF;
      end
    end
    // target side; strobes are single-cycle unless renewed
    next_s.lo_n = 1'b1;
    next_s.hi_n = 1'b1;
    if (s.acc_n) begin
      if (pci_tgt_start_i && (special || |whit || pci_tgt_cap_hit_i || pci_tgt_rom_hit_i)) begin
        next_s.acc_n = 1'b0;
        next_s.cmd   = pci_tgt_cmd_i;
        next_s.hit   = special ? '0 : whit;
        next_s.cap   = !special && pci_tgt_cap_hit_i;
        next_s.rom   = !special && pci_tgt_rom_hit_i;
        next_s.rd    = !pci_tgt_cmd_i[LBB_CMD_WR_BIT];
        next_s.wide  = BUS_WIDE && |(whit & WIN_WIDE);
        next_s.be    = next_s.wide ? pci_tgt_be_i : {LBB_BE_OFF, pci_tgt_be_i[3:0]};
      end
    end else if (pci_tgt_end_i) begin
      next_s.acc_n  = 1'b1;
      next_s.hit    = '0;
      next_s.cap    = 1'b0;
      next_s.rom    = 1'b0;
      next_s.wready = 1'b0;
    end else if (s.cmd != LBB_CMD_SPECIAL) begin
      if (s.rd) begin
        // a word is taken in every cycle the local side is ready and the read fifo has room
        push        = !target_ready_n_i && fifo_rdy;
        next_s.lo_n = !push;
        next_s.hi_n = !(push && s.wide);
      end else begin
        // ready seen last cycle lets one pci word through
        wtake         = pci_tgt_wvalid_i && s.wready;
        next_s.wready = !target_ready_n_i;
        if (wtake) begin
          next_s.wdata = pci_tgt_wdata_i & (s.wide ? '1 : LOW_MASK);
          next_s.lo_n  = 1'b0;
          next_s.hi_n  = !s.wide;
        end
      end
    end
    // master side
    next_s.req_seen = req_any;
    next_s.gnt_seen = !pci_gnt_n_i;
    next_s.mgnt_n   = pci_gnt_n_i;
    next_s.preq_n   = !req_any;
    next_s.mlo_n    = 1'b1;
    next_s.mhi_n    = 1'b1;
    case (s.phase)
      LBB_M_TERM: begin
        // requests count only here; fields come with the request
        if (s.req_seen && s.gnt_seen && req_any) begin
          next_s.phase = LBB_M_ADDR;
          next_s.maddr = master_start_addr_i;
          next_s.mcmd  = master_command_in_i;
          next_s.mlen  = master_burst_len_i;
          next_s.mwide = BUS_WIDE && !master_wide_request_n_i && master_narrow_request_n_i;
        end
      end
      LBB_M_ADDR: begin
        // a request held here is ignored; the data phase count loads, zero length counting as one
        next_s.phase = LBB_M_XACT;
        next_s.mcnt  = (s.mlen == '0) ? BL_W'(1) : s.mlen;
      end
      LBB_M_XACT: begin
        if (pci_mst_xfer_i) begin
          next_s.mlo_n = 1'b0;
          next_s.mhi_n = !s.mwide;
          next_s.mcnt  = s.mcnt - 1'b1;
        end
        if (pci_mst_stop_i || (pci_mst_xfer_i && s.mcnt == BL_W'(1))) begin
          next_s.phase = LBB_M_TERM;
        end
      end
      default: begin
        next_s.phase = LBB_M_TERM;
      end
    endcase
  end
  // state register; idle levels of active-low signals are high
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s        <= '0;
      s.acc_n  <= 1'b1;
      s.lo_n   <= 1'b1;
      s.hi_n   <= 1'b1;
      s.phase  <= LBB_M_TERM;
      s.preq_n <= 1'b1;
      s.mgnt_n <= 1'b1;
      s.mlo_n  <= 1'b1;
      s.mhi_n  <= 1'b1;
      // byte enables are low true, so idle means every lane off
      s.be     <= {LBB_BE_OFF, LBB_BE_OFF};
    end else begin
      s <= next_s;
    end
  end
  // outputs straight from the state register
  assign cfg_rdata_o              = s.cfg_rdata;
  assign pci_tgt_wready_o         = s.wready;
  assign target_access_active_n_o = s.acc_n;
  assign window_hit_o             = s.hit;
  assign cap_hit_o                = s.cap;
  assign rom_hit_o                = s.rom;
  assign target_command_code_o    = s.cmd;
  assign target_byte_enables_o    = s.be;
  assign target_write_data_o      = s.wdata;
  assign target_low_transfer_n_o  = s.lo_n;
  assign target_high_transfer_n_o = s.hi_n;
  assign master_grant_n_o         = s.mgnt_n;
  assign master_phase_state_o     = s.phase;
  assign master_low_transfer_n_o  = s.mlo_n;
  assign master_high_transfer_n_o = s.mhi_n;
  assign pci_req_n_o              = s.preq_n;
  assign pci_mst_wide_o           = s.mwide;
  assign pci_mst_addr_o           = s.maddr;
  assign pci_mst_cmd_o            = s.mcmd;
  assign pci_mst_len_o            = s.mlen;
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_req_gnt;
    s.phase == LBB_M_TERM && !master_narrow_request_n_i && !pci_gnt_n_i;
  endsequence
  sequence s_load_run;
    s.phase == LBB_M_ADDR ##1 s.phase == LBB_M_XACT;
  endsequence
  a_unused_zero: assert property (
    cfg_rd_i && (!idx_ok || !wen[cfg_idx_i]) |=> cfg_rdata_o == 32'h0)
    else $error("unused window did not read zero");
  a_mem_type: assert property (
    cfg_rd_i && idx_ok && wen[cfg_idx_i] && !wtype[cfg_idx_i][0]
    |=> !cfg_rdata_o[0] && !cfg_rdata_o[1])
    else $error("memory window type bits wrong");
  a_io_type: assert property (
    cfg_rd_i && idx_ok && wen[cfg_idx_i] && wtype[cfg_idx_i][0]
    |=> cfg_rdata_o[1:0] == 2'b01)
    else $error("io window type bits wrong");
  a_size_back: assert property (
    cfg_wr_i && idx_ok && cfg_wdata_i == LBB_WIN_ALL_ONES && !cfg_rd_i
    ##1 cfg_rd_i && !cfg_wr_i && cfg_idx_i == $past(cfg_idx_i) && wen[cfg_idx_i]
    |=> cfg_rdata_o == ($past(wmask[cfg_idx_i]) | $past(wtype[cfg_idx_i])))
    else $error("size read back wrong");
  a_special_nohit: assert property (
    !target_access_active_n_o && target_command_code_o == LBB_CMD_SPECIAL
    |-> window_hit_o == '0 && !cap_hit_o && !rom_hit_o)
    else $error("special cycle shows a hit");
  a_end_clears: assert property (
    $rose(target_access_active_n_o) |-> window_hit_o == '0 && !cap_hit_o && !rom_hit_o)
    else $error("hits left after access end");
  a_read_strobe: assert property (
    !s.acc_n && s.rd && s.cmd != LBB_CMD_SPECIAL && !pci_tgt_end_i
    && !target_ready_n_i && fifo_rdy |=> !target_low_transfer_n_o)
    else $error("read strobe missing after ready");
  a_narrow_high: assert property (
    !s.wide |-> target_high_transfer_n_o && target_byte_enables_o[7:4] == LBB_BE_OFF)
    else $error("upper lanes used on narrow window");
  a_grant_follow: assert property (
    ##1 master_grant_n_o == $past(pci_gnt_n_i))
    else $error("local grant does not follow pci grant");
  a_addr_load: assert property (
    s_req_gnt ##1 (s.phase == LBB_M_TERM && !master_narrow_request_n_i) |=> s_load_run)
    else $error("request and grant did not start loading");
  a_xfer_phase: assert property (
    !master_low_transfer_n_o |-> $past(s.phase) == LBB_M_XACT)
    else $error("master strobe outside transaction");
  a_master_high: assert property (
    !master_high_transfer_n_o |-> !master_low_transfer_n_o && s.mwide)
    else $error("master high strobe without wide transfer");
endmodule

// ==== test/lbb_partner.sv ====
// local application model: target data source and master requester
`timescale 1ns/1ps
module lbb_partner (
  // clock, reset and bench control
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 stall_i,
  input  wire logic                 go_i,
  // local target
  input  wire logic                 access_n_i,
  output logic                      ready_n_o,
  output logic [63:0]               rdata_o,
  // local master
  input  wire lbb_pkg::lbb_mphase_t phase_i,
  output logic                      req_n_o,
  output logic [31:0]               addr_o
);
  import lbb_pkg::*;
  // ready only inside an open access, so a stall really holds the core off
  assign ready_n_o = access_n_i | stall_i;
  // outside an access the word is inverted, so a stale capture shows up
  assign rdata_o = access_n_i ? ~64'h5a5a_c3c3_0f0f_9696 : 64'h5a5a_c3c3_0f0f_9696;
  // address steady whenever the request is raised
  assign addr_o = 32'h0000_1000;
  // request only from termination, released once address loading is seen
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_n_o <= 1'b1;
    end else if (phase_i == LBB_M_ADDR) begin
      req_n_o <= 1'b1;
    end else if (go_i && phase_i == LBB_M_TERM) begin
      req_n_o <= 1'b0;
    end
  end
endmodule

// ==== test/lbb_core_tb.sv ====
// self-checking bench of the local bus bridge core
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
`define WT(c) begin k = 0; while (!(c) && k < 60) begin @(negedge core_clk_i); k++; end \
  if (k == 60) begin mismatches++; end_of_test(); end end
module lbb_core_tb;
  import lbb_pkg::*;
  // window 0 wide 1MB memory, 1 io 8 byte, 3 narrow 4KB prefetch, rest unused
  localparam logic [191:0] WP = {64'h0, 32'hffff_f008, 32'h0, 32'hffff_fff9, 32'hfff0_0000};
  localparam logic [63:0] PAT = 64'h5a5a_c3c3_0f0f_9696; // word the partner serves
  logic core_clk_i, rst_b_i, cfg_wr_i, cfg_rd_i, pci_tgt_start_i, pci_tgt_end_i, go, stall;
  logic pci_tgt_cap_hit_i, pci_tgt_rom_hit_i, pci_tgt_wvalid_i, pci_tgt_rready_i;
  logic target_ready_n_i, master_narrow_request_n_i, master_wide_request_n_i;
  logic pci_gnt_n_i, pci_mst_xfer_i, pci_mst_stop_i, pci_tgt_wready_o, pci_tgt_rvalid_o;
  logic target_access_active_n_o, cap_hit_o, rom_hit_o, master_grant_n_o, pci_req_n_o;
  logic target_low_transfer_n_o, target_high_transfer_n_o, pci_mst_wide_o;
  logic master_low_transfer_n_o, master_high_transfer_n_o;
  logic [2:0] cfg_idx_i;
  logic [5:0] window_hit_o;
  logic [3:0] pci_tgt_cmd_i, master_command_in_i, target_command_code_o, pci_mst_cmd_o;
  logic [7:0] pci_tgt_be_i, target_byte_enables_o, master_burst_len_i, pci_mst_len_o;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, pci_tgt_addr_i, master_start_addr_i, pci_mst_addr_o;
  logic [63:0] pci_tgt_wdata_i, pci_tgt_rdata_o, target_read_data_in_i, target_write_data_o;
  lbb_mphase_t master_phase_state_o;
  int mismatches, total_checks, k, seed;
  logic [63:0] w;
  lbb_core #(.WIN_PARAM(WP), .WIN_WIDE(6'h01)) i_lbb_core (.*);
  lbb_partner i_lbb_partner (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
    .go_i(go), .access_n_i(target_access_active_n_o), .ready_n_o(target_ready_n_i),
    .rdata_o(target_read_data_in_i), .phase_i(master_phase_state_o),
    .req_n_o(master_narrow_request_n_i), .addr_o(master_start_addr_i));
  // free-running clock, 50 ns period
  initial begin
    core_clk_i = 0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // drain side of the read fifo stalls at random
  always @(posedge core_clk_i) pci_tgt_rready_i <= 1'($random(seed));
  // readback of a window: size mask kept, type bits fixed, unused reads zero
  function automatic logic [31:0] exp_win(input logic [2:0] i, input logic [31:0] d);
    logic [31:0] p, lo;
    p = (i < 6) ? WP[i*32+:32] : 32'h0;
    lo = p[0] ? 32'h3 : 32'hf;
    return (d & p & ~lo) | (p & lo);
  endfunction
  // write a window and read it straight back
  task automatic cfg(input logic [2:0] i, input logic [31:0] d);
    @(posedge core_clk_i);
    cfg_wr_i <= 1; cfg_idx_i <= i; cfg_wdata_i <= d;
    @(posedge core_clk_i);
    cfg_wr_i <= 0; cfg_rd_i <= 1;
    @(posedge core_clk_i);
    cfg_rd_i <= 0;
    @(negedge core_clk_i);
    `CHK("cfg_rdata", exp_win(i, d), cfg_rdata_o)
  endtask
  // open a target access and check what the local side is shown
  task automatic tgt(input logic [3:0] c, input logic [31:0] a, input logic [5:0] h);
    @(posedge core_clk_i);
    pci_tgt_start_i <= 1; pci_tgt_cmd_i <= c; pci_tgt_addr_i <= a;
    @(posedge core_clk_i);
    pci_tgt_start_i <= 0;
    @(negedge core_clk_i);
    `CHK("access_n", 1'b0, target_access_active_n_o)
    `CHK("command", c, target_command_code_o)
    `CHK("hits", h, window_hit_o)
  endtask
  // close the access: hits must drop with access
  task automatic fin;
    @(posedge core_clk_i);
    pci_tgt_end_i <= 1;
    @(posedge core_clk_i);
    pci_tgt_end_i <= 0;
    @(negedge core_clk_i);
    `CHK("access_n end", 1'b1, target_access_active_n_o)
    `CHK("hits end", 6'h00, window_hit_o)
    `CHK("cap rom end", 2'b00, {cap_hit_o, rom_hit_o})
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    seed = 39211; mismatches = 0; total_checks = 0; go = 0; stall = 0; rst_b_i = 0;
    {cfg_wr_i, cfg_rd_i, pci_tgt_start_i, pci_tgt_end_i, pci_tgt_wvalid_i} = '0;
    {pci_tgt_cap_hit_i, pci_tgt_rom_hit_i, pci_mst_xfer_i, pci_mst_stop_i} = '0;
    {cfg_idx_i, cfg_wdata_i, pci_tgt_addr_i, pci_tgt_cmd_i, pci_tgt_wdata_i} = '0;
    pci_tgt_be_i = 8'h00; master_wide_request_n_i = 1; pci_gnt_n_i = 1;
    master_command_in_i = 4'h6; master_burst_len_i = 8'h01;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1;
    // random bases, then sizing writes on every index, then a fixed base on window 0
    repeat (4) cfg(3'($random(seed) % 4), $random(seed));
    for (int i = 0; i < 8; i++) cfg(3'(i), 32'hffff_ffff);
    cfg(3'h0, 32'h0040_0000);
    $display("test window setup done");
    // wide burst read with no waits
    tgt(4'h6, 32'h0040_0010, 6'h01);
    `WT(!target_low_transfer_n_o)
    `CHK("high strobe rd", 1'b0, target_high_transfer_n_o)
    @(negedge core_clk_i);
    `CHK("burst strobe", 1'b0, target_low_transfer_n_o)
    `WT(pci_tgt_rvalid_o)
    `CHK("read word", PAT, pci_tgt_rdata_o)
    fin();
    // capability and rom hits open an access with no window selected
    @(posedge core_clk_i);
    pci_tgt_cap_hit_i <= 1;
    pci_tgt_rom_hit_i <= 1;
    tgt(4'h6, 32'h0000_0100, 6'h00);
    `CHK("cap rom", 2'b11, {cap_hit_o, rom_hit_o})
    fin();
    // special cycle selects no window, even with cap and rom offered
    tgt(4'h1, 32'h0040_0010, 6'h00);
    `CHK("cap rom special", 2'b00, {cap_hit_o, rom_hit_o})
    pci_tgt_cap_hit_i <= 0;
    pci_tgt_rom_hit_i <= 0;
    fin();
    $display("test target read done");
    // narrow write held off by a stalled local target
    stall <= 1;
    w = {$random(seed), $random(seed)};
    tgt(4'h7, 32'hffff_f010, 6'h08);
    `CHK("upper be", 4'hf, target_byte_enables_o[7:4])
    @(posedge core_clk_i);
    pci_tgt_wvalid_i <= 1;
    pci_tgt_wdata_i <= w;
    repeat (3) @(negedge core_clk_i);
    `CHK("stalled strobe", 1'b1, target_low_transfer_n_o)
    stall <= 0;
    `WT(pci_tgt_wready_o)
    @(posedge core_clk_i);
    pci_tgt_wvalid_i <= 0;
    `WT(!target_low_transfer_n_o)
    `CHK("write word", {32'h0, w[31:0]}, target_write_data_o)
    `CHK("high strobe wr", 1'b1, target_high_transfer_n_o)
    fin();
    $display("test target write done");
    // master single transfer, narrow request
    @(posedge core_clk_i);
    go <= 1;
    pci_gnt_n_i <= 0;
    `WT(master_phase_state_o == LBB_M_ADDR)
    `CHK("grant", 1'b0, master_grant_n_o)
    go <= 0;
    @(negedge core_clk_i);
    `CHK("latched addr", 32'h0000_1000, pci_mst_addr_o)
    `CHK("latched cmd", 4'h6, pci_mst_cmd_o)
    `CHK("phase xact", LBB_M_XACT, master_phase_state_o)
    @(posedge core_clk_i);
    pci_mst_xfer_i <= 1;
    @(posedge core_clk_i);
    pci_mst_xfer_i <= 0;
    @(negedge core_clk_i);
    `CHK("m low strobe", 1'b0, master_low_transfer_n_o)
    `CHK("m high strobe", 1'b1, master_high_transfer_n_o)
    `CHK("phase term", LBB_M_TERM, master_phase_state_o)
    // wide request alone, burst of two cut short by a stop
    @(posedge core_clk_i);
    master_wide_request_n_i <= 0;
    master_burst_len_i <= 8'h02;
    `WT(master_phase_state_o == LBB_M_ADDR)
    `CHK("pci req", 1'b0, pci_req_n_o)
    `CHK("wide flag", 1'b1, pci_mst_wide_o)
    `CHK("latched len", 8'h02, pci_mst_len_o)
    @(posedge core_clk_i);
    master_wide_request_n_i <= 1;
    pci_mst_xfer_i <= 1;
    @(posedge core_clk_i);
    pci_mst_xfer_i <= 0;
    pci_mst_stop_i <= 1;
    @(negedge core_clk_i);
    `CHK("m high wide", 1'b0, master_high_transfer_n_o)
    `CHK("phase burst", LBB_M_XACT, master_phase_state_o)
    @(posedge core_clk_i);
    pci_mst_stop_i <= 0;
    @(negedge core_clk_i);
    `CHK("phase stop", LBB_M_TERM, master_phase_state_o)
    $display("test master done");
    end_of_test();
  end
endmodule
